// file: hdl/modem_regs_pkg.sv
package modem_regs_pkg;

  // register port geometry
  localparam int ADDR_W     = 7;
  localparam int DATA_W     = 16;
  localparam int HDR_BITS   = 8;
  localparam int FRAME_BITS = 24;
  localparam logic [4:0] HDR_LAST_BIT   = 5'h07;
  localparam logic [4:0] FRAME_LAST_BIT = 5'h17;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 7'h02;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 7'h20;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 7'h21;
  localparam logic [ADDR_W-1:0] OFS_LINK   = 7'h22;

  // reset values and writable bits
  localparam logic [DATA_W-1:0] CONFIG_RESET = 16'h8042;
  localparam logic [DATA_W-1:0] CONFIG_WMASK = 16'hF05F;
  localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] MASK_RESET   = 16'h0024;
  localparam logic [DATA_W-1:0] MASK_WMASK   = 16'h7FFF;
  localparam logic [DATA_W-1:0] LINK_RESET   = 16'h0048;
  localparam logic [DATA_W-1:0] LINK_WMASK   = 16'hF1FD;
  localparam logic [DATA_W-1:0] STICKY_BITS  = 16'h9F00;

  // event status bit positions
  localparam int ST_RESET  = 15;
  localparam int ST_JREL   = 14;
  localparam int ST_JTRIP  = 13;
  localparam int ST_GAP    = 12;
  localparam int ST_FRAME  = 11;
  localparam int ST_PARITY = 10;
  localparam int ST_WDOG   = 9;
  localparam int ST_CRC    = 8;
  localparam int ST_RX_LO  = 5;
  localparam int ST_TX_LO  = 2;
  localparam int ST_CARR   = 1;
  localparam int ST_CTS    = 0;

  // host configuration fields
  localparam int CFG_IRQ_POL  = 3;
  localparam int CFG_IRQ_HOLD = 2;

  // link control fields
  localparam int LC_POL    = 15;
  localparam int LC_PRE_HI = 14;
  localparam int LC_PRE_LO = 12;
  localparam int LC_AMP_HI = 8;
  localparam int LC_AMP_LO = 4;
  localparam int LC_EN     = 3;
  localparam int LC_LOOP   = 2;
  localparam int LC_RTS    = 0;

  // manchester line timing
  localparam int CLK_HZ       = 50_000_000;
  localparam int BIT_RATE_HZ  = 31_250;
  localparam int HALF_BIT_CYC = CLK_HZ / (2 * BIT_RATE_HZ);
  localparam logic [9:0] HALF_LAST        = 10'(HALF_BIT_CYC - 1);
  localparam logic [7:0] PREAMBLE_PATTERN = 8'h55;
  localparam logic [2:0] LAST_BIT_IDX     = 3'h7;

  typedef enum logic [1:0] {TX_IDLE, TX_PREAMBLE, TX_DATA} tx_state_t;

endpackage

// file: hdl/reg_port_if.sv
`timescale 1ns/1ns
interface reg_port_if;
  import modem_regs_pkg::*;
  logic              wr_stb;
  logic              rd_stb;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport port (output wr_stb, rd_stb, addr, wdata, input rdata);
  modport regs (input wr_stb, rd_stb, addr, wdata, output rdata);
endinterface

// file: hdl/spi_reg_port.sv
`timescale 1ns/1ns
module spi_reg_port
  import modem_regs_pkg::*;
(
  // clock and reset
  input  wire logic  clock,
  input  wire logic  rst,
  input  wire logic  ce,
  // serial pins
  input  wire logic  sclk,
  input  wire logic  cs_n,
  input  wire logic  sdi,
  output logic       sdo_ff,
  output logic       sdo_oe_n_ff,
  // register side
  reg_port_if.port   bus
);

  logic [2:0]        sclk_sync_ff;
  logic [1:0]        csn_sync_ff;
  logic [1:0]        sdi_sync_ff;
  logic [4:0]        bit_cnt_ff;
  logic [22:0]       shift_ff;
  logic              rd_frame_ff;
  logic              hdr_done_ff;
  logic [DATA_W-1:0] rdshift_ff;
  logic              rise;
  logic              fall;
  logic              active;
  logic              data_phase;

  // pins cross from the host: two flops before use, a third only for edge detection
  always_ff @(posedge clock) begin
    if (rst) begin
      sclk_sync_ff <= 3'h0;
      csn_sync_ff  <= 2'h3;
      sdi_sync_ff  <= 2'h0;
    end else if (ce) begin
      sclk_sync_ff <= {sclk_sync_ff[1:0], sclk};
      csn_sync_ff  <= {csn_sync_ff[0], cs_n};
      sdi_sync_ff  <= {sdi_sync_ff[0], sdi};
    end
  end

  assign rise       = sclk_sync_ff[1] & ~sclk_sync_ff[2];
  assign fall       = ~sclk_sync_ff[1] & sclk_sync_ff[2];
  assign active     = ~csn_sync_ff[1];
  assign data_phase = bit_cnt_ff >= 5'(HDR_BITS);

  // frame: read flag, 7-bit address, 16 data bits, msb first, sampled on rising sclk
  always_ff @(posedge clock) begin
    if (rst) begin
      bit_cnt_ff  <= 5'h0;
      shift_ff    <= 23'h0;
      rd_frame_ff <= 1'b0;
      hdr_done_ff <= 1'b0;
      bus.addr    <= 7'h0;
      bus.wdata   <= 16'h0;
      bus.wr_stb  <= 1'b0;
    end else if (ce) begin
      hdr_done_ff <= 1'b0;
      bus.wr_stb  <= 1'b0;
      if (!active) begin
        bit_cnt_ff  <= 5'h0; // aborted write frames are dropped; a read past its header still strobes
        rd_frame_ff <= 1'b0;
      end else if (rise && bit_cnt_ff <= FRAME_LAST_BIT) begin
        shift_ff   <= {shift_ff[21:0], sdi_sync_ff[1]};
        bit_cnt_ff <= bit_cnt_ff + 5'h1;
        if (bit_cnt_ff == HDR_LAST_BIT) begin
          bus.addr    <= {shift_ff[5:0], sdi_sync_ff[1]};
          rd_frame_ff <= shift_ff[6];
          hdr_done_ff <= 1'b1;
        end
        if (bit_cnt_ff == FRAME_LAST_BIT) begin
          bus.wdata  <= {shift_ff[14:0], sdi_sync_ff[1]};
          bus.wr_stb <= ~rd_frame_ff;
        end
      end
    end
  end

  // read data is captured one cycle after the header so the address has settled
  always_ff @(posedge clock) begin
    if (rst) begin
      bus.rd_stb  <= 1'b0;
      rdshift_ff  <= 16'h0;
      sdo_ff      <= 1'b0;
      sdo_oe_n_ff <= 1'b1;
    end else if (ce) begin
      bus.rd_stb  <= hdr_done_ff & rd_frame_ff;
      sdo_oe_n_ff <= ~(active & rd_frame_ff & data_phase);
      if (bus.rd_stb) begin
        rdshift_ff <= bus.rdata;
      end else if (fall && active && rd_frame_ff && data_phase) begin
        sdo_ff     <= rdshift_ff[DATA_W-1];
        rdshift_ff <= {rdshift_ff[DATA_W-2:0], 1'b0};
      end
    end
  end

endmodule

// file: hdl/modem_event_status_irq.sv
`timescale 1ns/1ns
// Contract
// RL1: events set their status flag to one
// RL2: flags clear only by writing one
// RL3: carrier, queue, jabber flags follow live
// RL4: clear-to-send needs request and no carrier; code ignores carrier in loopback
// RL5: bit 15 records a reset
// RL6: bit 14 jabber timeout expired
// RL7: bit 13 jabber inhibitor triggered
// RL8: bit 12 character gap error
// RL9: bit 11 framing error or half-bit slip
// RL10: bit 10 received parity error
// RL11: bit 9 watchdog expired
// RL12: bit 8 host command bad check word
// RL13: bits 7-2 receive and transmit queue flags
// RL14: bit 1 read-only carrier present
// RL15: bit 0 read-only clear to send
// RL16: mask zero passes event, one blocks
// RL17: masked events still set status flags
// RL18: mask resets to 0x0024
// RL19: link control resets 0x0048, field layout
// RL20: pulse per event or hold until read
// RL21: polarity bit picks manchester one transition
// RL22: preamble bytes equal field plus one
// RL23: loopback routes transmit bytes to receive
// RL24: interrupt on masked-in rising flag, programmable polarity
module modem_event_status_irq
  import modem_regs_pkg::*;
(
  // clock, reset, clock enable
  input  wire logic       CLOCK,
  input  wire logic       RST,
  input  wire logic       CE,
  // serial register port
  input  wire logic       SCLK,
  input  wire logic       CS_N,
  input  wire logic       SDI,
  output logic            SDO,
  output logic            SDO_OE_N,
  // event pulses from modem logic
  input  wire logic       GAP_ERR,
  input  wire logic       FRAME_ERR,
  input  wire logic       PARITY_ERR,
  input  wire logic       WATCHDOG_EXPIRE,
  input  wire logic       CRC_ERR,
  // live conditions from modem logic
  input  wire logic       JABBER_RELEASE,
  input  wire logic       JABBER_TRIP,
  input  wire logic [2:0] RX_QUEUE_FLAGS,
  input  wire logic [2:0] TX_QUEUE_FLAGS,
  input  wire logic       CARRIER_PRESENT,
  // transmit queue output
  input  wire logic       TX_VALID,
  input  wire logic [7:0] TX_BYTE,
  output logic            TX_READY,
  // demodulator output
  input  wire logic       DEMOD_VALID,
  input  wire logic [7:0] DEMOD_BYTE,
  // receive queue input
  output logic            RX_VALID,
  output logic [7:0]      RX_BYTE,
  // line and analog controls
  output logic            MANCHESTER_OUT,
  output logic            MOD_ACTIVE,
  output logic            LINK_ENABLE,
  output logic [4:0]      TRANSMIT_AMPLITUDE,
  // interrupt pin
  output logic            IRQ
);

  reg_port_if bus ();

  logic [DATA_W-1:0] config_ff;
  logic [DATA_W-1:0] mask_ff;
  logic [DATA_W-1:0] link_ff;
  logic [DATA_W-1:0] sticky_ff;
  logic [DATA_W-1:0] nxt_sticky;
  logic [DATA_W-1:0] prev_status_ff;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] event_set;
  logic              reset_seen_ff;
  logic              cts_ff;
  logic              irq_hold_ff;
  logic              nxt_irq_hold;
  logic              irq_event;
  logic              irq_active;
  logic              status_read;
  tx_state_t         tx_state_ff;
  logic [9:0]        half_cnt_ff;
  logic              half_ff;
  logic [2:0]        bit_idx_ff;
  logic [7:0]        tx_shift_ff;
  logic [7:0]        data_hold_ff;
  logic [2:0]        pre_left_ff;
  logic              accept;
  logic              half_done;

  // register write hit for a given offset
  function automatic logic wr_hit(input logic stb, input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    return stb && (a == ofs);
  endfunction

  // merge writable bits of a write into a register
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] cur, input logic [DATA_W-1:0] wd,
                                              input logic [DATA_W-1:0] wm);
    return (cur & ~wm) | (wd & wm);
  endfunction

  spi_reg_port u_port (
    .clock       (CLOCK),
    .rst         (RST),
    .ce          (CE),
    .sclk        (SCLK),
    .cs_n        (CS_N),
    .sdi         (SDI),
    .sdo_ff      (SDO),
    .sdo_oe_n_ff (SDO_OE_N),
    .bus         (bus.port)
  );

  // hardware event sources, each forced to one in its own bit
  always_comb begin
    event_set             = 16'h0000;
    event_set[ST_RESET]   = ~reset_seen_ff;    // RL5
    event_set[ST_GAP]     = GAP_ERR;           // RL8
    event_set[ST_FRAME]   = FRAME_ERR;         // RL9
    event_set[ST_PARITY]  = PARITY_ERR;        // RL10
    event_set[ST_WDOG]    = WATCHDOG_EXPIRE;   // RL11
    event_set[ST_CRC]     = CRC_ERR;           // RL12
  end

  // sticky flags: a set in the same cycle as a write-one clear still lands
  always_comb begin
    nxt_sticky = sticky_ff;
    if (wr_hit(bus.wr_stb, bus.addr, OFS_STATUS)) begin
      nxt_sticky = sticky_ff & ~(bus.wdata & STICKY_BITS); // RL2
    end
    nxt_sticky = (nxt_sticky | event_set) & STICKY_BITS; // RL1 RL17
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sticky_ff     <= STATUS_RESET;
      reset_seen_ff <= 1'b0;
    end else if (CE) begin
      sticky_ff     <= nxt_sticky;
      reset_seen_ff <= 1'b1; // first enabled cycle after reset logs the reset event
    end
  end

  // clear-to-send: loopback counts as full duplex, so carrier does not gate it there
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      cts_ff <= 1'b0;
    end else if (CE) begin
      cts_ff <= link_ff[LC_RTS] & link_ff[LC_EN] & (link_ff[LC_LOOP] | ~CARRIER_PRESENT); // RL4
    end
  end

  // live bits are never stored in the sticky register, so a status write cannot disturb them
  always_comb begin
    status_word                           = sticky_ff;
    status_word[ST_JREL]                  = JABBER_RELEASE;  // RL3 RL6
    status_word[ST_JTRIP]                 = JABBER_TRIP;     // RL3 RL7
    status_word[ST_RX_LO+2:ST_RX_LO]      = RX_QUEUE_FLAGS;  // RL3 RL13
    status_word[ST_TX_LO+2:ST_TX_LO]      = TX_QUEUE_FLAGS;  // RL13
    status_word[ST_CARR]                  = CARRIER_PRESENT; // RL14
    status_word[ST_CTS]                   = cts_ff;          // RL15
  end

  // host configuration, mask and link control registers
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      config_ff <= CONFIG_RESET;
      mask_ff   <= MASK_RESET; // RL18
      link_ff   <= LINK_RESET; // RL19
    end else if (CE) begin
      if (wr_hit(bus.wr_stb, bus.addr, OFS_CONFIG)) begin
        config_ff <= merge(config_ff, bus.wdata, CONFIG_WMASK);
      end
      if (wr_hit(bus.wr_stb, bus.addr, OFS_MASK)) begin
        mask_ff <= merge(mask_ff, bus.wdata, MASK_WMASK); // RL16
      end
      if (wr_hit(bus.wr_stb, bus.addr, OFS_LINK)) begin
        link_ff <= merge(link_ff, bus.wdata, LINK_WMASK); // RL19
      end
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    unique case (bus.addr)
      OFS_CONFIG: bus.rdata = config_ff;
      OFS_STATUS: bus.rdata = status_word;
      OFS_MASK:   bus.rdata = mask_ff;
      OFS_LINK:   bus.rdata = link_ff;
      default:    bus.rdata = 16'h0000;
    endcase
  end

  // interrupt source: rising edge of any flag whose mask bit is clear
  assign irq_event   = |(status_word & ~prev_status_ff & ~mask_ff); // RL16 RL24
  assign status_read = bus.rd_stb && (bus.addr == OFS_STATUS);

  // hold mode: a new event wins over the clearing read of the same cycle
  always_comb begin
    nxt_irq_hold = irq_hold_ff;
    if (status_read) begin
      nxt_irq_hold = 1'b0;
    end
    if (irq_event) begin
      nxt_irq_hold = 1'b1;
    end
    if (!config_ff[CFG_IRQ_HOLD]) begin
      nxt_irq_hold = 1'b0;
    end
  end

  assign irq_active = config_ff[CFG_IRQ_HOLD] ? nxt_irq_hold : irq_event; // RL20

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      prev_status_ff <= STATUS_RESET;
      irq_hold_ff    <= 1'b0;
      IRQ            <= 1'b1; // idle level of the default active-low pin
    end else if (CE) begin
      prev_status_ff <= status_word;
      irq_hold_ff    <= nxt_irq_hold;
      IRQ            <= config_ff[CFG_IRQ_POL] ? irq_active : ~irq_active; // RL24
    end
  end

  // control outputs mirror the link register
  assign LINK_ENABLE        = link_ff[LC_EN];
  assign TRANSMIT_AMPLITUDE = link_ff[LC_AMP_HI:LC_AMP_LO];

  // in loopback the transmit byte is consumed at once and never reaches the line
  assign accept    = TX_VALID && TX_READY;
  assign half_done = half_cnt_ff == HALF_LAST;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      RX_VALID <= 1'b0;
      RX_BYTE  <= 8'h00;
    end else if (CE) begin
      RX_VALID <= 1'b0;
      if (link_ff[LC_LOOP]) begin
        if (accept) begin
          RX_VALID <= 1'b1; // RL23
          RX_BYTE  <= TX_BYTE;
        end
      end else if (DEMOD_VALID && link_ff[LC_EN]) begin
        RX_VALID <= 1'b1;
        RX_BYTE  <= DEMOD_BYTE;
      end
    end
  end

  // manchester transmitter: preamble bytes then one data byte, msb first
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      tx_state_ff  <= TX_IDLE;
      half_cnt_ff  <= 10'h000;
      half_ff      <= 1'b0;
      bit_idx_ff   <= 3'h0;
      tx_shift_ff  <= 8'h00;
      data_hold_ff <= 8'h00;
      pre_left_ff  <= 3'h0;
      TX_READY     <= 1'b0;
    end else if (CE) begin
      TX_READY <= 1'b0;
      unique case (tx_state_ff)
        TX_IDLE: begin
          TX_READY <= link_ff[LC_EN] & ~accept;
          if (accept && !link_ff[LC_LOOP]) begin
            data_hold_ff <= TX_BYTE;
            tx_shift_ff  <= PREAMBLE_PATTERN;
            pre_left_ff  <= link_ff[LC_PRE_HI:LC_PRE_LO]; // RL22
            half_cnt_ff  <= 10'h000;
            half_ff      <= 1'b0;
            bit_idx_ff   <= 3'h0;
            tx_state_ff  <= TX_PREAMBLE;
          end
        end
        TX_PREAMBLE, TX_DATA: begin
          if (!link_ff[LC_EN]) begin
            tx_state_ff <= TX_IDLE; // disabling the modem aborts the frame
          end else if (half_done) begin
            half_cnt_ff <= 10'h000;
            half_ff     <= ~half_ff;
            if (half_ff) begin
              bit_idx_ff  <= bit_idx_ff + 3'h1;
              tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
              if (bit_idx_ff == LAST_BIT_IDX) begin
                if (tx_state_ff == TX_DATA) begin
                  tx_state_ff <= TX_IDLE;
                end else if (pre_left_ff == 3'h0) begin
                  tx_shift_ff <= data_hold_ff; // RL22
                  tx_state_ff <= TX_DATA;
                end else begin
                  pre_left_ff <= pre_left_ff - 3'h1; // RL22
                  tx_shift_ff <= PREAMBLE_PATTERN;
                end
              end
            end
          end else begin
            half_cnt_ff <= half_cnt_ff + 10'h001;
          end
        end
      endcase
    end
  end

  // line level: first half carries the bit, flipped by the polarity setting
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      MANCHESTER_OUT <= 1'b0;
      MOD_ACTIVE     <= 1'b0;
    end else if (CE) begin
      MOD_ACTIVE <= tx_state_ff != TX_IDLE;
      if (tx_state_ff == TX_IDLE) begin
        MANCHESTER_OUT <= 1'b0;
      end else begin
        MANCHESTER_OUT <= tx_shift_ff[7] ^ link_ff[LC_POL] ^ half_ff; // RL21
      end
    end
  end

endmodule

// file: verif/modem_event_status_irq_asserts.sv
`timescale 1ns/1ns
module modem_event_status_irq_asserts
  import modem_regs_pkg::*;
(
  // clock and reset
  input wire logic       CLOCK,
  input wire logic       RST,
  input wire logic       CE,
  // byte paths
  input wire logic       TX_VALID,
  input wire logic [7:0] TX_BYTE,
  input wire logic       TX_READY,
  input wire logic       DEMOD_VALID,
  input wire logic [7:0] DEMOD_BYTE,
  input wire logic       RX_VALID,
  input wire logic [7:0] RX_BYTE,
  // line, controls, interrupt
  input wire logic       MANCHESTER_OUT,
  input wire logic       MOD_ACTIVE,
  input wire logic       LINK_ENABLE,
  input wire logic [4:0] TRANSMIT_AMPLITUDE,
  input wire logic       IRQ
);
  localparam logic [15:0] RUN_ONE = 16'(HALF_BIT_CYC - 1);
  localparam logic [15:0] RUN_TWO = 16'(2 * HALF_BIT_CYC - 1);
  logic        last_ff;
  logic        seen_ff;
  logic [15:0] run_ff;
  logic        moved;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  assign moved = MANCHESTER_OUT != last_ff;
  // line level one cycle back
  always_ff @(posedge CLOCK) begin
    last_ff <= MANCHESTER_OUT;
  end
  // run length between line changes; first change of a frame skipped, its run is cut short by the idle clear
  always_ff @(posedge CLOCK) begin
    if (RST || !MOD_ACTIVE) begin
      run_ff  <= 16'h0000;
      seen_ff <= 1'b0;
    end else if (moved) begin
      run_ff  <= 16'h0000;
      seen_ff <= 1'b1;
    end else begin
      run_ff <= run_ff + 16'h0001;
    end
  end
  AST_RESET_LINK: assert property ($fell(RST) |-> LINK_ENABLE && TRANSMIT_AMPLITUDE == 5'h04)
    else $error("link outputs wrong after reset");
  AST_RESET_IRQ: assert property ($fell(RST) |-> IRQ ##[1:2] !IRQ ##1 IRQ)
    else $error("no single reset interrupt pulse");
  AST_TX_TAKE: assert property (CE && TX_VALID && TX_READY |=> !TX_READY)
    else $error("ready held after byte taken");
  AST_TX_READY_EN: assert property (TX_READY |-> $past(LINK_ENABLE))
    else $error("ready while link disabled");
  AST_RX_SOURCE: assert property (RX_VALID |-> ($past(DEMOD_VALID) && RX_BYTE == $past(DEMOD_BYTE))
    || ($past(TX_VALID && TX_READY) && RX_BYTE == $past(TX_BYTE)))
    else $error("receive byte without source");
  AST_RX_GATE: assert property (!LINK_ENABLE && DEMOD_VALID |=> !RX_VALID)
    else $error("receive while link disabled");
  AST_LINE_IDLE: assert property (!MOD_ACTIVE [*3] |-> !MANCHESTER_OUT)
    else $error("line not low when idle");
  AST_HALF_BIT: assert property (MOD_ACTIVE && seen_ff && moved |-> run_ff == RUN_ONE || run_ff == RUN_TWO)
    else $error("half bit length wrong");
  cover property (TX_VALID && TX_READY);
  cover property (RX_VALID && $past(DEMOD_VALID));
  cover property (MOD_ACTIVE && seen_ff && moved);
endmodule
bind modem_event_status_irq modem_event_status_irq_asserts modem_event_status_irq_asserts_i (
  .CLOCK(CLOCK), .RST(RST), .CE(CE), .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE), .TX_READY(TX_READY),
  .DEMOD_VALID(DEMOD_VALID), .DEMOD_BYTE(DEMOD_BYTE), .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE),
  .MANCHESTER_OUT(MANCHESTER_OUT), .MOD_ACTIVE(MOD_ACTIVE), .LINK_ENABLE(LINK_ENABLE),
  .TRANSMIT_AMPLITUDE(TRANSMIT_AMPLITUDE), .IRQ(IRQ));

// file: verif/spi_host_model.sv
`timescale 1ns/1ns
module spi_host_model
  import modem_regs_pkg::*;
(
  // system clock for pacing
  input  wire logic clock,
  // serial pins
  input  wire logic sdo,
  input  wire logic sdo_oe_n,
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi
);
  localparam int HALF = 8; // sclk phase in clocks, above the 4 the synchroniser needs
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  // one 24-bit frame msb first; pins move on falling clock edges only
  task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q);
    logic [FRAME_BITS-1:0] w;
    w = {rd, a, d};
    q = '0;
    @(negedge clock);
    cs_n = 1'b0;
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      sdi = w[i];
      repeat (HALF) @(negedge clock);
      sclk = 1'b1;
      // an undriven data pin reads as unknown so it never passes for data
      if (i < DATA_W) q[i] = sdo_oe_n ? 1'bx : sdo;
      repeat (HALF) @(negedge clock);
      sclk = 1'b0;
    end
    repeat (6) @(negedge clock);
    cs_n = 1'b1;
    sdi  = ~sdi; // released data line shows no stale bit
    repeat (6) @(negedge clock);
  endtask
endmodule

// file: verif/modem_event_status_irq_tb.sv
`timescale 1ns/1ns
module modem_event_status_irq_tb;
  import modem_regs_pkg::*;
  logic        clock, rst, ce, sclk, cs_n, sdi, sdo, sdo_oe_n;
  logic [4:0]  ev;
  logic        jrel, jtrip, carr, rts, tx_valid, tx_ready, demod_valid, rx_valid;
  logic [2:0]  rxq, txq;
  logic [7:0]  tx_byte, demod_byte, rx_byte;
  logic        mout, mact, lnk_en, irq, irq_act;
  logic [4:0]  amp;
  logic [15:0] q;
  int          error_cnt, tests_run, seed, cyc, irq_cnt, c;
  modem_event_status_irq modem_event_status_irq_i (
    .CLOCK(clock), .RST(rst), .CE(ce), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .SDO(sdo), .SDO_OE_N(sdo_oe_n),
    .GAP_ERR(ev[4]), .FRAME_ERR(ev[3]), .PARITY_ERR(ev[2]), .WATCHDOG_EXPIRE(ev[1]), .CRC_ERR(ev[0]),
    .JABBER_RELEASE(jrel), .JABBER_TRIP(jtrip), .RX_QUEUE_FLAGS(rxq), .TX_QUEUE_FLAGS(txq),
    .CARRIER_PRESENT(carr), .TX_VALID(tx_valid), .TX_BYTE(tx_byte), .TX_READY(tx_ready),
    .DEMOD_VALID(demod_valid), .DEMOD_BYTE(demod_byte), .RX_VALID(rx_valid), .RX_BYTE(rx_byte),
    .MANCHESTER_OUT(mout), .MOD_ACTIVE(mact), .LINK_ENABLE(lnk_en), .TRANSMIT_AMPLITUDE(amp), .IRQ(irq));
  spi_host_model spi_host_model_i (
    .clock(clock), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // cycle budget and count of cycles with the interrupt pin active; sampled mid-cycle where the pin has settled
  always @(negedge clock) begin
    cyc = cyc + 1;
    if (irq === irq_act) irq_cnt = irq_cnt + 1;
    if (cyc == 99000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] e);
    tests_run++;
    if (got !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    spi_host_model_i.xfer(1'b0, a, d, q);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [15:0] e);
    spi_host_model_i.xfer(1'b1, a, 16'h0000, q);
    chk(q, e);
  endtask
  task automatic pulse(input int i); // one-cycle event
    @(negedge clock);
    ev[i] = 1'b1;
    @(negedge clock);
    ev = 5'h00;
  endtask
  // live status image: sticky part clear, clear-to-send with link on and loopback off
  function automatic logic [15:0] live_exp(input logic r);
    return {1'b0, jrel, jtrip, 5'h00, rxq, txq, carr, r & ~carr};
  endfunction
  // line level of half k of the preamble-then-data stream
  function automatic logic line_exp(input logic [7:0] b, input int pre, input int k, input logic pol);
    logic [7:0] v;
    v = (k / 16 > pre) ? b : 8'h55;
    return v[7 - (k / 2) % 8] ^ pol ^ k[0];
  endfunction
  // wait until ready is seen, raise valid for one cycle, then, when loop is set, look for the looped byte
  task automatic send(input logic [7:0] b, input logic loop);
    for (int t = 0; t < 50 && tx_ready !== 1'b1; t++) @(negedge clock);
    tx_valid = 1'b1;
    tx_byte  = b;
    @(negedge clock);
    tx_valid = 1'b0;
    if (loop) chk({7'h00, rx_valid, rx_byte}, {7'h00, 1'b1, b});
  endtask
  task automatic man(input logic [15:0] lc, input int pre, input logic pol);
    logic [7:0] b;
    b = 8'($random(seed));
    wr(OFS_LINK, lc);
    send(b, 1'b0);
    for (int t = 0; t < 3000 && mout !== 1'b1; t++) @(negedge clock);
    repeat (HALF_BIT_CYC / 2) @(negedge clock);
    for (int k = pol ? 0 : 1; k < 16 * (pre + 2); k++) begin
      chk({14'h0000, mact, mout}, {15'h0001, line_exp(b, pre, k, pol)});
      repeat (HALF_BIT_CYC) @(negedge clock);
    end
    chk({15'h0000, mact}, 16'h0000);
  endtask
  initial begin
    {rst, ce, ev, jrel, jtrip, carr, rts, rxq, txq, tx_valid, tx_byte, demod_valid, demod_byte} = '0;
    {error_cnt, tests_run, cyc, irq_cnt, irq_act} = '0;
    seed = 63776;
    rst  = 1'b1;
    ce   = 1'b1;
    repeat (6) @(posedge clock);
    @(negedge clock) rst = 1'b0;
    repeat (10) @(negedge clock);
    chk(16'(irq_cnt), 16'h0001);
    rd_chk(OFS_STATUS, 16'h8000);
    rd_chk(OFS_MASK, 16'h0024);
    rd_chk(OFS_LINK, 16'h0048);
    rd_chk(7'h10, 16'h0000);
    wr(OFS_STATUS, 16'h0000);
    rd_chk(OFS_STATUS, 16'h8000);
    wr(OFS_STATUS, 16'h8000);
    rd_chk(OFS_STATUS, 16'h0000);
    wr(OFS_MASK, 16'hFFFF);
    rd_chk(OFS_MASK, 16'h7FFF);
    wr(OFS_LINK, 16'hFFFF);
    rd_chk(OFS_LINK, 16'hF1FD);
    chk({10'h000, lnk_en, amp}, 16'h003F);
    wr(OFS_LINK, 16'h0048);
    // each sticky event but the reset, alternately masked and unmasked
    for (int n = 0; n < 5; n++) begin
      wr(OFS_MASK, n[0] ? 16'h7FFF : 16'h7FFF ^ (16'h0001 << (8 + n)));
      c = irq_cnt;
      pulse(n);
      repeat (5) @(negedge clock);
      chk(16'(irq_cnt - c), n[0] ? 16'h0000 : 16'h0001);
      rd_chk(OFS_STATUS, 16'h0001 << (8 + n));
      wr(OFS_STATUS, 16'h0001 << (8 + n));
      rd_chk(OFS_STATUS, 16'h0000);
    end
    // a frozen block misses an event that comes and goes while the enable is low
    ce = 1'b0;
    pulse(0);
    ce = 1'b1;
    rd_chk(OFS_STATUS, 16'h0000);
    // hold mode keeps the pin until status is read, then active-high polarity
    wr(OFS_MASK, 16'h7EFF);
    wr(OFS_CONFIG, 16'h8046);
    pulse(0);
    repeat (20) @(negedge clock);
    chk({15'h0000, irq}, 16'h0000);
    rd_chk(OFS_STATUS, 16'h0100);
    repeat (4) @(negedge clock);
    chk({15'h0000, irq}, 16'h0001);
    wr(OFS_STATUS, 16'h0100);
    wr(OFS_CONFIG, 16'h804A);
    irq_act = 1'b1;
    c = irq_cnt;
    pulse(0);
    repeat (5) @(negedge clock);
    chk(16'(irq_cnt - c), 16'h0001);
    wr(OFS_STATUS, 16'h0100);
    wr(OFS_CONFIG, 16'h8042);
    irq_act = 1'b0;
    // live flags follow their inputs and ignore writes
    wr(OFS_MASK, 16'h7FFF);
    for (int n = 0; n < 6; n++) begin
      {jrel, jtrip, rxq, txq, carr, rts} = 10'($random(seed));
      if (n == 0) {carr, rts} = 2'b01;
      wr(OFS_LINK, {15'h0024, rts});
      wr(OFS_STATUS, 16'h60FF);
      rd_chk(OFS_STATUS, live_exp(rts));
    end
    {jrel, jtrip, rxq, txq, carr} = '0;
    // loopback, back to back
    wr(OFS_LINK, 16'h004C);
    for (int n = 0; n < 4; n++) send(8'($random(seed)), 1'b1);
    chk({15'h0000, mact}, 16'h0000);
    // link disabled refuses traffic
    wr(OFS_LINK, 16'h0040);
    @(negedge clock) demod_valid = 1'b1;
    @(negedge clock) demod_valid = 1'b0;
    chk({13'h0000, lnk_en, tx_ready, rx_valid}, 16'h0000);
    wr(OFS_LINK, 16'h0048);
    demod_byte = 8'($random(seed));
    @(negedge clock) demod_valid = 1'b1;
    @(negedge clock) demod_valid = 1'b0;
    chk({7'h00, rx_valid, rx_byte}, {7'h01, demod_byte});
    man(16'h1048, 1, 1'b0);
    man(16'h8048, 0, 1'b1);
    report_and_stop();
  end
endmodule
